// ---- bench/irq_cause_reg_assertions.sv ----
`timescale 1ns/10ps
module irq_cause_checker (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire scs_n_i,
  input wire battery_sense_i,
  input wire [11:0] irq_enable_i,
  input wire sdo_oe_o,
  input wire irq_out_n_o,
  input wire enable_wr_o,
  input wire [11:0] enable_data_o
);
  // Covers the pin hold window so event checks start only once it ends
  logic [7:0] hold;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i)
      hold <= 8'h00;
    else if (!scs_n_i)
      hold <= 8'hFF;
    else if (hold != 8'h00)
      hold <= hold - 8'h01;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_oe_on: assert property ($fell(scs_n_i) |=> sdo_oe_o)
    else $error("sdo_oe_o not raised");
  a_oe_off: assert property ($rose(scs_n_i) |=> !sdo_oe_o)
    else $error("sdo_oe_o not dropped");
  a_wr_one_pulse: assert property (enable_wr_o |=> !enable_wr_o)
    else $error("enable_wr_o too long");
  a_wr_after_cs: assert property (enable_wr_o |->
    $past(scs_n_i) && !$past(scs_n_i, 2))
    else $error("enable_wr_o off frame end");
  a_data_held: assert property (!enable_wr_o |->
    $stable(enable_data_o))
    else $error("enable_data_o moved");
  a_pin_released: assert property (enable_wr_o |-> irq_out_n_o)
    else $error("pin low at read");
  a_pin_hold: assert property (enable_wr_o |=> irq_out_n_o [*8])
    else $error("pin hold too short");
  a_event_pin: assert property ($fell(battery_sense_i)
    && irq_enable_i[7] && hold == 8'h00 && scs_n_i |=> ##[0:2] !irq_out_n_o)
    else $error("pin not asserted");
  a_flag_sticks: assert property (!irq_out_n_o && scs_n_i
    && $past(scs_n_i) && $stable(irq_enable_i) |=> !irq_out_n_o)
    else $error("pin released early");
endmodule // irq_cause_checker

bind irq_cause_reg irq_cause_checker chk_u (.clk_sys_i, .resetn_i,
  .scs_n_i, .battery_sense_i, .irq_enable_i, .sdo_oe_o, .irq_out_n_o,
  .enable_wr_o, .enable_data_o);

// ---- bench/sbc_interrupt_status_read_tb.sv ----
`timescale 1ns/10ps
`include "irq_cause_defs.vh"
module sbc_interrupt_status_read_tb;
  logic clk_sys_i = 1'h0;
  logic resetn_i, temp_s, bat_s, r1_s, r3_s, wake_s, rst_e, tmo_e, lw_e;
  logic [2:0] lin_s;
  logic [15:0] rx;
  wire scs_n, sck, sdi, sdo, sdo_oe, irq_n, wr;
  wire [11:0] wdata;
  int error_cnt, comparisons, wr_cnt, k;
  int bits[8] = '{11, 10, 7, 6, 4, 3, 2, 0};
  always #5 clk_sys_i = ~clk_sys_i;
  // Counted on the falling edge, where the registered pulse has settled
  always @(negedge clk_sys_i) if (wr) wr_cnt++;
  spi_host_model host_u (.clk_sys_i, .sdo_i(sdo), .scs_n_o(scs_n),
    .sck_o(sck), .sdi_o(sdi));
  irq_cause_reg dut_u (.clk_sys_i, .resetn_i, .ce_i(1'h1), .sck_i(sck),
    .sdi_i(sdi), .scs_n_i(scs_n), .temp_warning_state_i(temp_s),
    .battery_sense_i(bat_s), .reg1_ok_bit_i(r1_s), .reg3_ok_bit_i(r3_s),
    .lin_fail_status_i(lin_s), .local_wake_pin_i(wake_s),
    .wdt_restart_evt_i(rst_e), .wdt_timeout_evt_i(tmo_e),
    .lin_wake_evt_i(lw_e), .irq_enable_i(12'hDDD), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .irq_out_n_o(irq_n), .enable_wr_o(wr),
    .enable_data_o(wdata));
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task rd(logic [15:0] e);
    host_u.xfer(16'h7000, 16, rx);
    chk("cause", e, rx);
  endtask
  // Falling-edge sources return high; temp_s and lin_s stay changed, so only one edge counts
  task fire(int b);
    case (b)
      11: tmo_e = 1'h1;
      10: temp_s = ~temp_s;
      7: bat_s = 1'h0;
      6: r1_s = 1'h0;
      4: lin_s = lin_s + 3'h1;
      3: wake_s = 1'h0;
      2: rst_e = 1'h1;
      default: lw_e = 1'h1;
    endcase
    @(negedge clk_sys_i) {rst_e, tmo_e, lw_e} = 3'h0;
    @(negedge clk_sys_i) {bat_s, r1_s, r3_s, wake_s} = 4'hF;
  endtask
  task summarize;
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {resetn_i, temp_s, rst_e, tmo_e, lw_e, lin_s} = 8'h00;
    {bat_s, r1_s, r3_s, wake_s} = 4'hF;
    repeat (12) @(negedge clk_sys_i);
    resetn_i = 1'h1;
    repeat (3) @(negedge clk_sys_i);
    rd(16'h0000);
    foreach (bits[i]) begin
      repeat (`T_IRQ_OUT_N_CYC + 60) @(negedge clk_sys_i);
      fire(bits[i]);
      chk("pin", 16'h0000, irq_n);
      rd(16'h0001 << bits[i]);
      chk("pin", 16'h0001, irq_n);
      rd(16'h0000);
    end
    k = wr_cnt;
    r3_s = 1'h0;
    foreach (bits[i]) fire(bits[i]);
    host_u.xfer(16'h4ABC, 15, rx);
    rd(16'h0DDD);
    host_u.xfer(16'h6FFF, 17, rx);
    rd(16'h0100);
    chk("wr", k, wr_cnt);
    host_u.xfer(16'h6ABC, 16, rx);
    chk("wr", k + 1, wr_cnt);
    chk("data", 16'h0ABC, wdata);
    host_u.xfer(16'h7555, 16, rx);
    chk("wr", k + 1, wr_cnt);
    chk("data", 16'h0ABC, wdata);
    // A flag seen by the host and raised again mid-read must survive
    fire(7);
    fork
      rd(16'h0080);
      begin
        repeat (10) @(negedge clk_sys_i);
        fire(7);
      end
    join
    rd(16'h0080);
    // Reset in mid-run clears a pending flag
    fire(7);
    resetn_i = 1'h0;
    repeat (2) @(negedge clk_sys_i);
    resetn_i = 1'h1;
    repeat (2) @(negedge clk_sys_i);
    chk("pin", 16'h0001, irq_n);
    rd(16'h0000);
    summarize;
  end
endmodule // sbc_interrupt_status_read_tb

// ---- bench/spi_host_model.sv ----
`timescale 1ns/10ps
module spi_host_model (
  input wire clk_sys_i,
  input wire sdo_i,
  output logic scs_n_o,
  output logic sck_o,
  output logic sdi_o
);
  initial begin
    scs_n_o = 1'h1;
    sck_o = 1'h0;
    sdi_o = 1'h0;
  end
  // Sck stays high one clock and low two; nclk other than 16 is a fault
  task automatic xfer(input logic [15:0] tx, input int nclk,
    output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clk_sys_i) scs_n_o = 1'h0;
    for (int i = 0; i < nclk; i++) begin
      @(negedge clk_sys_i) sdi_o = tx[15 - i % 16];
      @(negedge clk_sys_i) sck_o = 1'h1;
      rx = {rx[14:0], sdo_i};
      @(negedge clk_sys_i) sck_o = 1'h0;
    end
    @(negedge clk_sys_i) scs_n_o = 1'h1;
    sdi_o = ~sdi_o;
    repeat (3) @(negedge clk_sys_i);
  endtask
endmodule // spi_host_model

// ---- design/irq_cause_defs.vh ----
`ifndef IRQ_CAUSE_DEFS_VH
`define IRQ_CAUSE_DEFS_VH

// ********************************************************
// Frame layout
// ********************************************************
`define FRAME_BITS 5'h10
`define ADDR_HI 15
`define ADDR_LO 14
`define READ_REG_CHOICE_BIT 13
`define READ_WITHOUT_WRITE_BIT 12
`define CAUSE_ADDR 2'h1

// ********************************************************
// Interrupt cause register
// ********************************************************
`define CAUSE_WIDTH 12
`define CAUSE_RESET 12'h000
`define CAUSE_VALID_MASK 12'hDDD
`define WDT_TIMEOUT_BIT 11
`define OVERTEMP_BIT 10
`define SPI_CLOCK_COUNT_BIT 8
`define BATTERY_FAIL_BIT 7
`define SUPPLY_FAIL_BIT 6
`define LIN_FAULT_BIT 4
`define LOCAL_WAKE_BIT 3
`define WDT_RESTART_BIT 2
`define LIN_WAKE_BIT 0
`define LIN_STATUS_WIDTH 3

// ********************************************************
// Timing
// ********************************************************
`define CLK_PERIOD_NS 10
`define T_IRQ_OUT_N_NS 2000
`define T_IRQ_OUT_N_CYC ((`T_IRQ_OUT_N_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_WIDTH 12

`endif

// ---- design/irq_cause_reg.v ----
// Overview of operation
// - Address 01 with bit12 set: read only
// - Address 01, bit12 clear: read, write enables
// - Bit 10 flags temperature warning change
// - Bits 9, 5, 1 always read zero
// - Bit 8 flags frames not sixteen clocks
// - Wrong clock count discards whole frame
// - Bit 7 flags battery sense falling edge
// - Bit 6 flags regulator one/three ok loss
// - Bit 4 flags LIN failure status change
// - Bit 3 flags local wake falling edge
// - Bit 2 flags watchdog restart while off
// - Read or reset clears; no events lost
// - Interrupt pin released awhile after read
// - Bit 11 flags standby watchdog overflow
// - Bit 0 flags LIN bus wake-up
`timescale 1ns/10ps
`include "irq_cause_defs.vh"

module irq_cause_reg (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire ce_i,
  input wire sck_i,
  input wire sdi_i,
  input wire scs_n_i,
  input wire temp_warning_state_i,
  input wire battery_sense_i,
  input wire reg1_ok_bit_i,
  input wire reg3_ok_bit_i,
  input wire [`LIN_STATUS_WIDTH-1:0] lin_fail_status_i,
  input wire local_wake_pin_i,
  input wire wdt_restart_evt_i,
  input wire wdt_timeout_evt_i,
  input wire lin_wake_evt_i,
  input wire [`CAUSE_WIDTH-1:0] irq_enable_i,
  output wire sdo_o,
  output wire sdo_oe_o,
  output reg irq_out_n_o,
  output reg enable_wr_o,
  output reg [`CAUSE_WIDTH-1:0] enable_data_o
);

  // ********************************************************
  // Decode helpers
  // ********************************************************
  function is_cause_addr;
    input [15:0] word;
    begin
      is_cause_addr = (word[`ADDR_HI:`ADDR_LO] == `CAUSE_ADDR);
    end
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  localparam [`CAUSE_WIDTH-1:0] VALID_MASK = `CAUSE_VALID_MASK;
  // The hold count is an integer; only the counter's width is loaded
  localparam [31:0] HOLD_LOAD = `T_IRQ_OUT_N_CYC;

  reg [`CAUSE_WIDTH-1:0] cause;
  reg [`CAUSE_WIDTH-1:0] snap;
  reg [`CAUSE_WIDTH-1:0] fresh;
  reg [`HOLD_CNT_WIDTH-1:0] hold_cnt;
  reg primed;
  reg tws_q;
  reg sense_q;
  reg ok1_q;
  reg ok3_q;
  reg [`LIN_STATUS_WIDTH-1:0] lin_q;
  reg wake_q;

  wire frame_start;
  wire frame_done;
  wire frame_ok;
  wire [15:0] rx_word;
  wire read_hit;
  reg [`CAUSE_WIDTH-1:0] set_vec;
  wire [`CAUSE_WIDTH-1:0] clr_vec;
  wire [`CAUSE_WIDTH-1:0] next_cause;
  reg next_irq_out_n;

  // ********************************************************
  // Serial frame port
  // ********************************************************
  // Upper command bits echo as zero; the host only needs the flags
  spi_frame_port u_port (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .sck_i(sck_i),
    .sdi_i(sdi_i),
    .scs_n_i(scs_n_i),
    .load_word_i({4'h0, cause}),
    .frame_start_o(frame_start),
    .frame_done_o(frame_done),
    .frame_ok_o(frame_ok),
    .rx_word_o(rx_word),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o)
  );

  // Only a complete frame to the cause address counts as a read
  assign read_hit = frame_ok & is_cause_addr(rx_word);

  // ********************************************************
  // Source event detection
  // ********************************************************
  // Edges are ignored until one sample exists, so reset is no edge
  always @* begin
    set_vec = `CAUSE_RESET;
    set_vec[`WDT_TIMEOUT_BIT] = wdt_timeout_evt_i;
    set_vec[`OVERTEMP_BIT] = primed &
      (tws_q ^ temp_warning_state_i);
    set_vec[`SPI_CLOCK_COUNT_BIT] = frame_done & ~frame_ok;
    set_vec[`BATTERY_FAIL_BIT] = primed &
      sense_q & ~battery_sense_i;
    set_vec[`SUPPLY_FAIL_BIT] = primed &
      ((ok1_q & ~reg1_ok_bit_i) | (ok3_q & ~reg3_ok_bit_i));
    set_vec[`LIN_FAULT_BIT] = primed &
      (|(lin_q ^ lin_fail_status_i));
    set_vec[`LOCAL_WAKE_BIT] = primed &
      wake_q & ~local_wake_pin_i;
    set_vec[`WDT_RESTART_BIT] = wdt_restart_evt_i;
    set_vec[`LIN_WAKE_BIT] = lin_wake_evt_i;
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      primed <= 1'b0;
      tws_q <= 1'b0;
      sense_q <= 1'b0;
      ok1_q <= 1'b0;
      ok3_q <= 1'b0;
      lin_q <= {`LIN_STATUS_WIDTH{1'b0}};
      wake_q <= 1'b0;
    end else if (ce_i) begin
      primed <= 1'b1;
      tws_q <= temp_warning_state_i;
      sense_q <= battery_sense_i;
      ok1_q <= reg1_ok_bit_i;
      ok3_q <= reg3_ok_bit_i;
      lin_q <= lin_fail_status_i;
      wake_q <= local_wake_pin_i;
    end
  end

  // ********************************************************
  // Read snapshot
  // ********************************************************
  // A flag raised after the word left for the host must survive the
  // clear, so only bits the host saw and nothing re-raised are cleared
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      snap <= `CAUSE_RESET;
      fresh <= `CAUSE_RESET;
    end else if (ce_i) begin
      if (frame_start) begin
        snap <= cause;
        fresh <= set_vec;
      end else begin
        fresh <= fresh | set_vec;
      end
    end
  end

  assign clr_vec = read_hit ? (snap & ~fresh & ~set_vec) :
    `CAUSE_RESET;

  // ********************************************************
  // Cause flags
  // ********************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `CAUSE_WIDTH; gi = gi + 1) begin : g_flag
      // Set wins over clear; reserved positions never store
      assign next_cause[gi] = VALID_MASK[gi] ?
        (set_vec[gi] | (cause[gi] & ~clr_vec[gi])) :
        1'b0;
      always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cause[gi] <= 1'b0;
        end else if (ce_i) begin
          cause[gi] <= next_cause[gi];
        end
      end
    end
  endgenerate

  // ********************************************************
  // Enable register write request
  // ********************************************************
  // The enable register lives outside; it is told once per good cause-address frame with bit12 clear
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_wr_o <= 1'b0;
      enable_data_o <= `CAUSE_RESET;
    end else if (ce_i) begin
      enable_wr_o <= read_hit &
        ~rx_word[`READ_WITHOUT_WRITE_BIT];
      if (read_hit & ~rx_word[`READ_WITHOUT_WRITE_BIT]) begin
        enable_data_o <= rx_word[`CAUSE_WIDTH-1:0];
      end
    end
  end

  // ********************************************************
  // Interrupt pin
  // ********************************************************
  // The release gap forces a new falling edge for pending flags
  always @* begin
    next_irq_out_n = 1'b1;
    if ((hold_cnt == {`HOLD_CNT_WIDTH{1'b0}}) && !read_hit) begin
      next_irq_out_n = ~(|(next_cause & irq_enable_i));
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_cnt <= {`HOLD_CNT_WIDTH{1'b0}};
      irq_out_n_o <= 1'b1;
    end else if (ce_i) begin
      if (read_hit) begin
        hold_cnt <= HOLD_LOAD[`HOLD_CNT_WIDTH-1:0];
      end else if (hold_cnt != {`HOLD_CNT_WIDTH{1'b0}}) begin
        hold_cnt <= hold_cnt - 1'b1;
      end
      irq_out_n_o <= next_irq_out_n;
    end
  end

endmodule // irq_cause_reg

// ---- design/spi_frame_port.v ----
`timescale 1ns/10ps
`include "irq_cause_defs.vh"

module spi_frame_port (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire ce_i,
  input wire sck_i,
  input wire sdi_i,
  input wire scs_n_i,
  input wire [15:0] load_word_i,
  output wire frame_start_o,
  output wire frame_done_o,
  output wire frame_ok_o,
  output wire [15:0] rx_word_o,
  output reg sdo_o,
  output reg sdo_oe_o
);

  reg sck_q;
  reg cs_n_q;
  reg [15:0] shift_in;
  reg [15:0] shift_out;
  reg [4:0] bit_cnt;

  wire cs_fall = cs_n_q & ~scs_n_i;
  wire cs_rise = ~cs_n_q & scs_n_i;
  wire sck_rise = ~sck_q & sck_i & ~scs_n_i;
  wire sck_fall = sck_q & ~sck_i & ~scs_n_i;

  assign frame_start_o = cs_fall;
  assign frame_done_o = cs_rise;
  // Any count but exactly sixteen voids the whole frame
  assign frame_ok_o = cs_rise & (bit_cnt == `FRAME_BITS);
  assign rx_word_o = shift_in;

  // ********************************************************
  // Shift engine
  // ********************************************************
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      shift_in <= 16'h0000;
      shift_out <= 16'h0000;
      bit_cnt <= 5'h00;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else if (ce_i) begin
      sck_q <= sck_i;
      cs_n_q <= scs_n_i;
      if (cs_fall) begin
        shift_out <= load_word_i;
        sdo_o <= load_word_i[15];
        sdo_oe_o <= 1'b1;
        bit_cnt <= 5'h00;
      end else if (cs_rise) begin
        sdo_oe_o <= 1'b0;
      end else begin
        if (sck_rise) begin
          shift_in <= {shift_in[14:0], sdi_i};
          // Saturate so that long frames stay recognisably wrong
          if (bit_cnt != 5'h1F) begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        if (sck_fall) begin
          shift_out <= {shift_out[14:0], 1'b0};
          sdo_o <= shift_out[14];
        end
      end
    end
  end

endmodule // spi_frame_port
